// ### pkg/lpmrc_pkg.sv
// package: constants and carrier types for the low-power mode and reset controller
package lpmrc_pkg;
    localparam int          CLK_MHZ         = 250;
    localparam int          RST_PULSE_NS    = 50;
    // fewest samples a minimum-width low pulse is sure to get
    localparam int          RST_PULSE_CYC   = (RST_PULSE_NS * CLK_MHZ) / 1000;
    localparam int          RST_HOLD_CYC    = 16;
    localparam int          NUM_WAKE_SRC    = 6;
    localparam int          NUM_GPREG       = 4;
    localparam logic [31:0] BOOT_VECTOR     = 32'h0000_0000;
    localparam logic [31:0] GPREG_RESET     = 32'h0000_0000;
    localparam logic [1:0]  BOD_LVL_RESET   = 2'h0;

    typedef enum logic [4:0] {
        LPMRC_RUN   = 5'h01,
        LPMRC_SLEEP = 5'h02,
        LPMRC_DSLP  = 5'h04,
        LPMRC_PDN   = 5'h08,
        LPMRC_DPD   = 5'h10
    } lpmrc_state_type;

    typedef enum logic [2:0] {
        LPMRC_REQ_NONE = 3'h0,
        LPMRC_REQ_SLP  = 3'h1,
        LPMRC_REQ_DSLP = 3'h2,
        LPMRC_REQ_PDN  = 3'h3,
        LPMRC_REQ_DPD  = 3'h4
    } lpmrc_req_type;

    // gating outputs, high means running or powered, except flash_standby, which is high in standby
    typedef struct packed {
        logic core_clk_en;
        logic periph_clk_en;
        logic clk_src_en;
        logic rc_osc_run;
        logic rc_osc_out_en;
        logic wdt_osc_run;
        logic analog_pwr;
        logic flash_standby;
        logic flash_pwr;
        logic logic_pwr;
        logic wake_timer_run;
    } lpmrc_gate_type;

    // order: pin interrupt, watchdog, usart sync slave, spi, i2c slave, brownout
    typedef struct packed {
        logic [NUM_WAKE_SRC-1:0] irq;
        logic [NUM_WAKE_SRC-1:0] system_config_block_en;
        logic [NUM_WAKE_SRC-1:0] ictl_en;
    } lpmrc_wake_type;

    localparam lpmrc_gate_type GATE_RUN = 11'h7f7;
endpackage

// ### hdl/lpmrc_ctrl.sv
// low-power mode sequencing and chip reset generation
module lpmrc_ctrl
    import lpmrc_pkg::*;
(
    // clock and reset
    input  wire logic           clk,
    input  wire logic           srst,
    // mode request from core
    input  wire lpmrc_req_type  mode_req,
    input  wire logic           dpd_lock,
    input  wire logic           wdt_osc_sel,
    input  wire logic           bod_keep_on,
    input  wire logic           wake_timer_en,
    // wake sources
    input  wire lpmrc_wake_type wake,
    input  wire logic           wake_timer_tmo,
    input  wire logic           wake_pin,
    // reset sources
    input  wire logic           reset_pin_n,
    input  wire logic           wdt_reset,
    input  wire logic           por,
    // brownout
    input  wire logic [3:0]     bod_below,
    input  wire logic [1:0]     bod_irq_lvl,
    input  wire logic [1:0]     bod_rst_lvl,
    input  wire logic           bod_rst_en,
    // retained registers, plus the gating outputs
    input  wire logic           gpreg_we,
    input  wire logic [1:0]     gpreg_idx,
    input  wire logic [31:0]    gpreg_wdata,
    output lpmrc_gate_type      gate,
    output logic [31:0]         gpreg_rdata,
    // status and reset outputs
    output lpmrc_state_type     mode_state,
    output logic                bod_irq,
    output logic                bod_status,
    output logic                chip_rst,
    output logic                flash_init,
    output logic [31:0]         fetch_addr,
    output logic [3:0]          rst_cause
);

    lpmrc_state_type st_r, st_nxt;
    logic [2:0]      pin_sync_r, wk_sync_r;
    logic [7:0]      low_cnt_r;
    logic [7:0]      hold_r;
    logic [31:0]     gpreg_r [NUM_GPREG];
    logic            pin_rst, bod_rst, any_rst, wake_irq;

    function automatic logic bod_pick(input logic [3:0] v, input logic [1:0] s);
        bod_pick = v[s];
    endfunction

    // pin inputs: three flops, change counts when last two agree
    always_ff @(posedge clk) begin
        pin_sync_r <= {pin_sync_r[1:0], reset_pin_n};
        wk_sync_r  <= {wk_sync_r[1:0], wake_pin};
    end

    // glitch on sync path is tolerated; a low lasting RST_PULSE_CYC counts
    always_ff @(posedge clk) begin
        if (srst) begin
            low_cnt_r <= 8'h00;
        end else if (pin_sync_r[2] | pin_sync_r[1]) begin
            low_cnt_r <= 8'h00;
        end else if (low_cnt_r != 8'hff) begin
            low_cnt_r <= low_cnt_r + 8'h01;
        end
    end
    // sync agreement and count latency eat two of the guaranteed samples
    assign pin_rst = (low_cnt_r >= 8'(RST_PULSE_CYC - 2)) & ~pin_sync_r[2] & ~pin_sync_r[1];

    assign bod_rst  = bod_rst_en & bod_pick(bod_below, bod_rst_lvl);
    assign any_rst  = srst | pin_rst | wdt_reset | por | bod_rst;
    assign wake_irq = |(wake.irq & wake.system_config_block_en & wake.ictl_en);

    // reset stretcher; hold keeps chip reset and flash init asserted
    always_ff @(posedge clk) begin
        if (any_rst) begin
            hold_r     <= 8'(RST_HOLD_CYC);
            chip_rst   <= 1'b1;
            flash_init <= 1'b1;
        end else if (hold_r != 8'h00) begin
            hold_r     <= hold_r - 8'h01;
            chip_rst   <= 1'b1;
            flash_init <= 1'b1;
        end else begin
            chip_rst   <= 1'b0;
            flash_init <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rst_cause <= 4'h0;
        end else if (pin_rst | wdt_reset | por | bod_rst) begin
            rst_cause <= {bod_rst, por, wdt_reset, pin_rst};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            fetch_addr <= BOOT_VECTOR;
        end else if (chip_rst) begin
            fetch_addr <= BOOT_VECTOR;
        end
    end

    // mode sequencer
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            LPMRC_RUN: begin
                case (mode_req)
                    LPMRC_REQ_SLP:  st_nxt = LPMRC_SLEEP;
                    LPMRC_REQ_DSLP: st_nxt = LPMRC_DSLP;
                    LPMRC_REQ_PDN:  st_nxt = LPMRC_PDN;
                    LPMRC_REQ_DPD:  st_nxt = dpd_lock ? LPMRC_RUN : LPMRC_DPD;
                    default:        st_nxt = LPMRC_RUN;
                endcase
            end
            LPMRC_SLEEP: begin
                if (|wake.irq) begin
                    st_nxt = LPMRC_RUN;
                end
            end
            LPMRC_DSLP: begin
                if (wake_irq) begin
                    st_nxt = LPMRC_RUN;
                end
            end
            LPMRC_PDN: begin
                if (wake_irq) begin
                    st_nxt = LPMRC_RUN;
                end
            end
            LPMRC_DPD: begin
                // wake pin low after sync agreement, or self wake timer
                if ((~wk_sync_r[2] & ~wk_sync_r[1]) | (wake_timer_en & wake_timer_tmo)) begin
                    st_nxt = LPMRC_RUN;
                end
            end
            default: st_nxt = LPMRC_RUN;
        endcase
    end

    // resets leave every mode
    always_ff @(posedge clk) begin
        if (any_rst) begin
            st_r <= LPMRC_RUN;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign mode_state = st_r;

    // gating is registered from the next state, so it changes with st_r
    always_ff @(posedge clk) begin
        // any reset cause forces run gating so rc restarts with the state
        if (any_rst) begin
            gate <= GATE_RUN;
        end else begin
            gate <= GATE_RUN;
            gate.rc_osc_run     <= 1'b1;
            gate.rc_osc_out_en  <= 1'b1;
            gate.wdt_osc_run    <= 1'b1;
            gate.wake_timer_run <= wake_timer_en;
            case (st_nxt)
                LPMRC_SLEEP: begin
                    gate.core_clk_en <= 1'b0;
                end
                LPMRC_DSLP: begin
                    gate.core_clk_en   <= 1'b0;
                    gate.periph_clk_en <= 1'b0;
                    gate.clk_src_en    <= 1'b0;
                    gate.rc_osc_out_en <= 1'b0;
                    gate.wdt_osc_run   <= wdt_osc_sel;
                    gate.analog_pwr    <= bod_keep_on;
                    gate.flash_standby <= 1'b1;
                end
                LPMRC_PDN: begin
                    gate.core_clk_en   <= 1'b0;
                    gate.periph_clk_en <= 1'b0;
                    gate.clk_src_en    <= 1'b0;
                    gate.rc_osc_run    <= 1'b0;
                    gate.rc_osc_out_en <= 1'b0;
                    gate.wdt_osc_run   <= wdt_osc_sel;
                    gate.analog_pwr    <= bod_keep_on;
                    gate.flash_pwr     <= 1'b0;
                end
                LPMRC_DPD: begin
                    gate <= '0;
                    gate.wake_timer_run <= wake_timer_en;
                end
                default: begin
                end
            endcase
        end
    end

    // retained registers: no reset so contents survive deep power-down
    always_ff @(posedge clk) begin
        if (gpreg_we && st_r == LPMRC_RUN) begin
            gpreg_r[gpreg_idx] <= gpreg_wdata;
        end
        gpreg_rdata <= gpreg_r[gpreg_idx];
    end

    // brownout interrupt and polled status
    always_ff @(posedge clk) begin
        if (srst) begin
            bod_irq    <= 1'b0;
            bod_status <= 1'b0;
        end else begin
            bod_irq    <= bod_pick(bod_below, bod_irq_lvl);
            bod_status <= bod_pick(bod_below, bod_irq_lvl);
        end
    end

    a_dpd_lock_holds: assert property (@(posedge clk) disable iff (srst)
        (st_r == LPMRC_RUN && mode_req == LPMRC_REQ_DPD && dpd_lock && !any_rst) |=> st_r == LPMRC_RUN)
        else $error("deep power-down entered while locked");
    a_sleep_core_off: assert property (@(posedge clk) disable iff (srst)
        (st_r == LPMRC_SLEEP && $past(st_r) == LPMRC_SLEEP) |-> !gate.core_clk_en && gate.periph_clk_en)
        else $error("sleep gating wrong");
    a_dslp_gating: assert property (@(posedge clk) disable iff (srst)
        (st_r == LPMRC_DSLP && $past(st_r) == LPMRC_DSLP) |-> !gate.periph_clk_en && gate.rc_osc_run
        && !gate.rc_osc_out_en)
        else $error("deep-sleep clock gating wrong");
    a_dslp_flash: assert property (@(posedge clk) disable iff (srst)
        (st_r == LPMRC_DSLP && $past(st_r) == LPMRC_DSLP) |-> gate.flash_standby && gate.flash_pwr)
        else $error("deep-sleep flash not standby");
    a_pdn_gating: assert property (@(posedge clk) disable iff (srst)
        (st_r == LPMRC_PDN && $past(st_r) == LPMRC_PDN) |-> !gate.rc_osc_run && !gate.flash_pwr)
        else $error("power-down gating wrong");
    a_wake_enables: assert property (@(posedge clk) disable iff (srst)
        (st_r == LPMRC_DSLP && !wake_irq && !any_rst) |=> st_r == LPMRC_DSLP)
        else $error("deep-sleep left without enabled wake");
    a_pdn_wake: assert property (@(posedge clk) disable iff (srst)
        (st_r == LPMRC_PDN && wake_irq) |=> st_r == LPMRC_RUN)
        else $error("power-down missed wake");
    a_dpd_power: assert property (@(posedge clk) disable iff (srst)
        (st_r == LPMRC_DPD && $past(st_r) == LPMRC_DPD) |-> !gate.logic_pwr && !gate.flash_pwr)
        else $error("deep power-down left logic powered");
    a_reset_hold: assert property (@(posedge clk)
        any_rst |=> chip_rst && flash_init ##1 chip_rst[*8])
        else $error("reset pulse too short");
    a_bod_reset: assert property (@(posedge clk) disable iff (srst)
        bod_rst |=> chip_rst && st_r == LPMRC_RUN)
        else $error("brownout did not reset");

endmodule // lpmrc_ctrl

// ### dv/lpmrc_pins_model.sv
// partner model: board-side wake and reset pins
module lpmrc_pins_model
(
    // bench commands
    input  wire logic wake_req,
    input  wire logic rst_req,
    // pins toward the block
    output logic      wake_pin,
    output logic      reset_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // released pins rest on their pull-ups, never float
    assign wake_pin    = ~wake_req;
    assign reset_pin_n = ~rst_req;
endmodule // lpmrc_pins_model

// ### dv/testbench.sv
// testbench: scenario tasks for the low-power mode and reset controller
module testbench
    import lpmrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, srst, dpd_lock, wdt_osc_sel, bod_keep_on, wake_timer_en, wake_timer_tmo;
    logic wake_pin, reset_pin_n, wdt_reset, por, bod_rst_en, gpreg_we, chip_rst, flash_init;
    logic bod_irq, bod_status, wake_req, rst_req;
    logic [3:0]      bod_below, rst_cause;
    logic [1:0]      bod_irq_lvl, bod_rst_lvl, gpreg_idx;
    logic [31:0]     gpreg_wdata, gpreg_rdata, fetch_addr;
    lpmrc_req_type   mode_req;
    lpmrc_wake_type  wake;
    lpmrc_gate_type  gate;
    lpmrc_state_type mode_state;
    int              miscompares = 0;
    int              n_checks = 0;

    lpmrc_ctrl DUT (.clk(clk), .srst(srst), .mode_req(mode_req), .dpd_lock(dpd_lock),
        .wdt_osc_sel(wdt_osc_sel), .bod_keep_on(bod_keep_on), .wake_timer_en(wake_timer_en),
        .wake(wake), .wake_timer_tmo(wake_timer_tmo), .wake_pin(wake_pin), .reset_pin_n(reset_pin_n),
        .wdt_reset(wdt_reset), .por(por), .bod_below(bod_below), .bod_irq_lvl(bod_irq_lvl),
        .bod_rst_lvl(bod_rst_lvl), .bod_rst_en(bod_rst_en), .gpreg_we(gpreg_we), .gpreg_idx(gpreg_idx),
        .gpreg_wdata(gpreg_wdata), .gate(gate), .gpreg_rdata(gpreg_rdata), .mode_state(mode_state),
        .bod_irq(bod_irq), .bod_status(bod_status), .chip_rst(chip_rst), .flash_init(flash_init),
        .fetch_addr(fetch_addr), .rst_cause(rst_cause));
    lpmrc_pins_model pins (.wake_req(wake_req), .rst_req(rst_req), .wake_pin(wake_pin),
        .reset_pin_n(reset_pin_n));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // inputs always move 1 ns after the edge
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic summarize();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk_w(string nm, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_b(string nm, logic exp, logic got);
        chk_w(nm, 32'(exp), 32'(got));
    endtask

    task automatic wait_st(lpmrc_state_type s, int lim);
        for (int i = 0; i < lim && mode_state !== s; i++) tick(1);
        chk_w("mode_state", 32'(s), 32'(mode_state));
        if (mode_state !== s) summarize();
    endtask

    task automatic wait_rst(logic v, int lim, output int c);
        for (c = 0; c < lim && chip_rst !== v; c++) tick(1);
        chk_b("chip_rst", v, chip_rst);
        if (chip_rst !== v) summarize();
    endtask

    task automatic enter(lpmrc_req_type r, lpmrc_state_type s);
        mode_req = r;
        wait_st(s, 4);
        mode_req = LPMRC_REQ_NONE;
    endtask

    task automatic t_reset();
        int c;
        chk_b("flash_init", 1'b1, flash_init);
        wait_rst(1'b0, 40, c);
        chk_w("fetch_addr", BOOT_VECTOR, fetch_addr);
        chk_w("mode_state", 32'(LPMRC_RUN), 32'(mode_state));
        chk_b("rc_osc_run", 1'b1, gate.rc_osc_run);
    endtask

    task automatic t_sleep();
        enter(LPMRC_REQ_SLP, LPMRC_SLEEP);
        chk_b("core_clk_en", 1'b0, gate.core_clk_en);
        chk_b("periph_clk_en", 1'b1, gate.periph_clk_en);
        wake.irq = 6'h20;
        wait_st(LPMRC_RUN, 4);
        wake = '0;
    endtask

    // first five listed sources (brownout not covered): one enable alone must not wake
    task automatic t_deep(lpmrc_req_type r, lpmrc_state_type s, logic keep);
        wdt_osc_sel = keep;
        bod_keep_on = ~keep;
        for (int k = 0; k < 5; k++) begin
            enter(r, s);
            chk_b("core_clk_en", 1'b0, gate.core_clk_en);
            chk_w("clk_gates", 32'h0, 32'({gate.periph_clk_en, gate.clk_src_en, gate.rc_osc_out_en}));
            chk_b("rc_osc_run", s == LPMRC_DSLP, gate.rc_osc_run);
            chk_b("wdt_osc_run", keep, gate.wdt_osc_run);
            chk_b("analog_pwr", ~keep, gate.analog_pwr);
            chk_b("flash_standby", s == LPMRC_DSLP, gate.flash_standby);
            if (s == LPMRC_PDN) begin
                chk_b("flash_pwr", 1'b0, gate.flash_pwr);
            end
            wake.irq = 6'(1 << k);
            wake.system_config_block_en = wake.irq;
            tick(4);
            chk_w("mode_state", 32'(s), 32'(mode_state));
            wake.system_config_block_en = 6'h0;
            wake.ictl_en = wake.irq;
            tick(4);
            chk_w("mode_state", 32'(s), 32'(mode_state));
            wake.system_config_block_en = wake.irq;
            wait_st(LPMRC_RUN, 4);
            wake = '0;
        end
    endtask

    task automatic t_dpd();
        int c;
        gpreg_we = 1'b1;
        for (int k = 0; k < NUM_GPREG; k++) begin
            gpreg_idx = 2'(k);
            gpreg_wdata = 32'ha5a5_0000 + 32'(k);
            tick(1);
        end
        gpreg_we = 1'b0;
        dpd_lock = 1'b1;
        mode_req = LPMRC_REQ_DPD;
        tick(6);
        chk_w("mode_state", 32'(LPMRC_RUN), 32'(mode_state));
        dpd_lock = 1'b0;
        wake_timer_en = 1'b1;
        enter(LPMRC_REQ_DPD, LPMRC_DPD);
        chk_b("logic_pwr", 1'b0, gate.logic_pwr);
        chk_b("wake_timer_run", 1'b1, gate.wake_timer_run);
        wake_timer_tmo = 1'b1;
        wait_st(LPMRC_RUN, 6);
        wake_timer_tmo = 1'b0;
        wake_timer_en = 1'b0;
        wait_rst(1'b0, 40, c);
        enter(LPMRC_REQ_DPD, LPMRC_DPD);
        chk_b("wake_timer_run", 1'b0, gate.wake_timer_run);
        gpreg_wdata = 32'h0;
        gpreg_we = 1'b1;
        tick(6);
        gpreg_we = 1'b0;
        chk_w("mode_state", 32'(LPMRC_DPD), 32'(mode_state));
        wake_req = 1'b1;
        wait_st(LPMRC_RUN, 8);
        wake_req = 1'b0;
        wait_rst(1'b0, 40, c);
        for (int k = 0; k < NUM_GPREG; k++) begin
            gpreg_idx = 2'(k);
            tick(1);
            chk_w("gpreg_rdata", 32'ha5a5_0000 + 32'(k), gpreg_rdata);
        end
    endtask

    task automatic t_rst();
        int c;
        rst_req = 1'b1;
        tick(RST_PULSE_CYC - 1);
        rst_req = 1'b0;
        tick(8);
        chk_b("chip_rst", 1'b0, chip_rst);
        rst_req = 1'b1;
        tick(RST_PULSE_CYC);
        rst_req = 1'b0;
        wait_rst(1'b1, 6, c);
        chk_b("cause_pin", 1'b1, rst_cause[0]);
        wait_rst(1'b0, 40, c);
        enter(LPMRC_REQ_PDN, LPMRC_PDN);
        wdt_reset = 1'b1;
        tick(1);
        wdt_reset = 1'b0;
        wait_rst(1'b1, 3, c);
        chk_b("rc_osc_run", 1'b1, gate.rc_osc_run);
        chk_b("flash_init", 1'b1, flash_init);
        wait_rst(1'b0, 40, c);
        chk_b("hold_len", 1'b1, c >= RST_HOLD_CYC && c <= RST_HOLD_CYC + 2);
        chk_b("cause_wdt", 1'b1, rst_cause[1]);
        chk_w("mode_state", 32'(LPMRC_RUN), 32'(mode_state));
        por = 1'b1;
        tick(1);
        por = 1'b0;
        wait_rst(1'b1, 3, c);
        chk_b("cause_por", 1'b1, rst_cause[2]);
        wait_rst(1'b0, 40, c);
    endtask

    task automatic t_bod();
        int c;
        for (int k = 0; k < 4; k++) begin
            bod_below = 4'(1 << k);
            bod_irq_lvl = 2'(k);
            tick(2);
            chk_b("bod_irq", 1'b1, bod_irq);
            chk_b("bod_status", 1'b1, bod_status);
            bod_irq_lvl = 2'(k + 1);
            bod_rst_lvl = 2'(k + 1);
            bod_rst_en = 1'b1;
            tick(3);
            chk_b("bod_irq", 1'b0, bod_irq);
            chk_b("chip_rst", 1'b0, chip_rst);
            bod_rst_lvl = 2'(k);
            wait_rst(1'b1, 4, c);
            chk_b("cause_bod", 1'b1, rst_cause[3]);
            bod_below = 4'h0;
            bod_rst_en = 1'b0;
            wait_rst(1'b0, 40, c);
        end
    endtask

    initial begin
        {srst, wake_req, rst_req} = 3'h4;
        {dpd_lock, wdt_osc_sel, bod_keep_on, wake_timer_en, wake_timer_tmo} = 5'h0;
        {wdt_reset, por, bod_rst_en, gpreg_we} = 4'h0;
        mode_req = LPMRC_REQ_NONE;
        wake = '0;
        bod_below = 4'h0;
        {bod_irq_lvl, bod_rst_lvl, gpreg_idx} = 6'h00;
        gpreg_wdata = 32'h0;
        tick(6);
        srst = 1'b0;
        t_reset();
        t_sleep();
        t_deep(LPMRC_REQ_DSLP, LPMRC_DSLP, 1'b1);
        t_deep(LPMRC_REQ_PDN, LPMRC_PDN, 1'b0);
        t_dpd();
        t_rst();
        t_bod();
        summarize();
    end
endmodule // testbench
